// ==== trs_defines.svh ====
// Offsets, word widths, reset values and timing counts of the run-status block
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

// Register map: control words at byte addresses, status words by index
`define TRS_CTRL1_ADDR      8'h00
`define TRS_CTRL2_ADDR      8'h04
`define TRS_STAT1_IDX       8'h0B
`define TRS_STAT2_IDX       8'h0D

// Control word layout and reset value
`define TRS_CTRL_W          7
`define TRS_CTRL_RESET      7'h00

// Status word width
`define TRS_STAT_W          16

// Machine code ranges
`define TRS_CODE_WAIT_MAX   10'h1F3
`define TRS_CODE_MAX        10'h3E7

// Initialization time and clock rate
`define TRS_INIT_TIME_MS    130
`define TRS_CLK_KHZ         200000
`define TRS_INIT_CYCLES     (`TRS_INIT_TIME_MS * `TRS_CLK_KHZ)

`endif

// ==== trs_pkg.sv ====
// Types shared by the run-status block and its neighbours
package trs_pkg;

    // Per-task run state, one-hot
    typedef enum logic [4:0] {
        TRS_IDLE = 5'h01,
        TRS_RUN  = 5'h02,
        TRS_OPT  = 5'h04,
        TRS_CODE = 5'h08,
        TRS_STOP = 5'h10
    } trs_run_type;

    // Host control bits of one task, bit 0 first from the right
    typedef struct packed {
        logic opt_input;
        logic code_reset;
        logic forced_end;
        logic pause;
        logic single_block;
        logic cycle_start;
        logic mode_auto;
    } trs_ctrl_type;

    // Status word of one task
    typedef struct packed {
        logic [5:0] rsvd_hi;
        logic       cs_recv;
        logic       strobe;
        logic       code_wait;
        logic       opt_wait;
        logic       completed;
        logic       running;
        logic       manual;
        logic       auto_mode;
        logic [1:0] rsvd_lo;
    } trs_status_type;

    // Events from the program engine of one task
    typedef struct packed {
        logic       prog_end;
        logic       code_out;
        logic [9:0] code;
        logic       block_step;
        logic       opt_stop;
        logic       opt_interp;
        logic       axes_stopped;
        logic       teach_start;
    } trs_event_type;

    // Commands to the program engine of one task
    typedef struct packed {
        logic start;
        logic run_go;
        logic pause;
        logic forced_end;
        logic single_block;
        logic auto_mode;
    } trs_cmd_type;

endpackage : trs_pkg

// ==== trs_task_status.sv ====
// Run-status flags of two tasks behind an APB register slave
// Register map, one 32-bit word per register:
//   0x00 task 1 control, 0x04 task 2 control (read/write)
//   0x2C task 1 status, 0x34 task 2 status (read only)
// Control word bits:
//   0 mode_auto (1 automatic), 1 cycle_start, 2 single_block,
//   3 pause, 4 forced_end, 5 code_reset, 6 opt_input
// Status word bits:
//   2 automatic, 3 manual, 4 running, 5 completed,
//   6 optional-input wait, 7 code-reset wait, 8 strobe,
//   9 start received; all other bits read zero
// Every transfer takes one wait state; unmapped addresses answer
//   with pslverr and zero data, and status writes are dropped.
// Limitation: completed is stored, so it hides in manual mode and
//   comes back in automatic mode until the next start.
//
`include "trs_defines.svh"

module trs_task_status #(
    parameter int unsigned INIT_CYCLES = `TRS_INIT_CYCLES,
    parameter int unsigned ADDR_W      = 8
) (
    // Clock and reset
    input  wire  logic                            pclk,
    input  wire  logic                            presetn,
    // APB slave
    input  wire  logic                            psel,
    input  wire  logic                            penable,
    input  wire  logic                            pwrite,
    input  wire  logic [ADDR_W-1:0]               paddr,
    input  wire  logic [31:0]                     pwdata,
    output logic       [31:0]                     prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Program engine, one entry per task
    input  wire  trs_pkg::trs_event_type [1:0]    eng_event,
    output trs_pkg::trs_cmd_type         [1:0]    eng_cmd,
    // Initialization finished
    output logic                                  init_done
);
    import trs_pkg::*;

    localparam int unsigned NUM_TASKS = 2;

    // Refuse settings the map and counter cannot serve
    initial begin
        if (ADDR_W < 8 || ADDR_W > 32 || INIT_CYCLES < 1) begin
            $error("trs_task_status: bad parameter");
        end
    end

    // Byte addresses of the status words
    localparam logic [7:0] STAT1_ADDR = 8'(`TRS_STAT1_IDX * 4);
    localparam logic [7:0] STAT2_ADDR = 8'(`TRS_STAT2_IDX * 4);

    trs_ctrl_type [NUM_TASKS-1:0]            ctrl;
    trs_ctrl_type [NUM_TASKS-1:0]            next_ctrl;
    logic [NUM_TASKS*`TRS_STAT_W-1:0]        status_all;
    logic [31:0]                             next_prdata;
    logic                                    next_pready;
    logic                                    next_pslverr;
    logic [31:0]                             init_cnt;
    logic [31:0]                             next_init_cnt;
    logic                                    next_init_done;

    // Initialization timer; mode flags wait for it to finish
    // A 32-bit count covers the default of 26 million edges
    always_comb begin
        next_init_cnt  = init_cnt;
        next_init_done = init_done;
        if (!init_done) begin
            if (init_cnt >= INIT_CYCLES - 1) begin
                next_init_done = 1'b1;
            end else begin
                next_init_cnt = init_cnt + 32'h0000_0001;
            end
        end
    end

    // Timer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt  <= 32'h0000_0000;
            init_done <= 1'b0;
        end else begin
            init_cnt  <= next_init_cnt;
            init_done <= next_init_done;
        end
    end

    // APB slave: one wait state, then read data and answer together
    always_comb begin
        logic        access;
        logic [7:0]  a;
        access       = psel && penable && !pready;
        a            = paddr[7:0];
        next_ctrl    = ctrl;
        next_prdata  = prdata;
        next_pready  = access;
        next_pslverr = 1'b0;
        // Shift rather than slice, so the default 8-bit map has no
        // empty range to select
        if (|(paddr >> 8)) begin
            a = 8'hFF;
        end
        if (access) begin
            next_prdata = 32'h0000_0000;
            // Status words read zero-filled above bit 15
            unique case (a)
                `TRS_CTRL1_ADDR:
                    next_prdata[`TRS_CTRL_W-1:0] = ctrl[0];
                `TRS_CTRL2_ADDR:
                    next_prdata[`TRS_CTRL_W-1:0] = ctrl[1];
                STAT1_ADDR:
                    next_prdata[15:0] = status_all[15:0];
                STAT2_ADDR:
                    next_prdata[15:0] = status_all[31:16];
                default:
                    next_pslverr = 1'b1;
            endcase
        end
        // Writes land on the edge that samples pready high
        if (psel && penable && pready && pwrite) begin
            if (a == `TRS_CTRL1_ADDR) begin
                next_ctrl[0] = trs_ctrl_type'(pwdata[`TRS_CTRL_W-1:0]);
            end
            if (a == `TRS_CTRL2_ADDR) begin
                next_ctrl[1] = trs_ctrl_type'(pwdata[`TRS_CTRL_W-1:0]);
            end
        end
    end

    // Control words and the registered bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= {NUM_TASKS{trs_ctrl_type'(`TRS_CTRL_RESET)}};
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Identical status logic for each task, each with its own word
    for (genvar t = 0; t < NUM_TASKS; t++) begin : g_task
        // State meaning: IDLE no program, RUN executing,
        // OPT waiting on the optional input, CODE waiting for the
        // code reset handshake, STOP decelerating after forced end
        trs_run_type    state;
        trs_run_type    next_state;
        logic           auto_f;
        logic           next_auto_f;
        logic           manual_f;
        logic           next_manual_f;
        logic           done_mem;
        logic           next_done_mem;
        // Previous start bit, for the rising-edge detect
        logic           cs_prev;
        logic           cs_recv;
        logic           next_cs_recv;
        logic           strobe;
        logic           next_strobe;
        logic           reset_seen;
        logic           next_reset_seen;
        logic           kind_stop;
        logic           next_kind_stop;
        trs_cmd_type    next_cmd;
        trs_status_type stat;

        always_comb begin
            trs_ctrl_type  c;
            trs_event_type e;
            logic          cs_edge;
            logic          start_req;
            c               = ctrl[t];
            e               = eng_event[t];
            cs_edge         = c.cycle_start && !cs_prev;
            next_state      = state;
            next_done_mem   = done_mem;
            next_strobe     = strobe;
            next_reset_seen = reset_seen;
            next_kind_stop  = kind_stop;
            // Mode flags follow the request only after initialization
            next_auto_f     = init_done && c.mode_auto;
            next_manual_f   = init_done && !c.mode_auto;
            // A start edge counts only in automatic mode
            start_req       = (cs_edge && auto_f)
                              || e.teach_start;
            next_cs_recv    = c.cycle_start
                              && (cs_recv || (cs_edge && auto_f));
            // Non-waiting codes drop the strobe at the next block
            if (strobe && state == TRS_RUN
                && (e.block_step || e.prog_end)) begin
                next_strobe = 1'b0;
            end
            // Any code in range raises the strobe
            // Set after the block clear: a new code beats a same-cycle block clear, but not the code-wait exit or the mode drop below
            if (e.code_out && e.code <= `TRS_CODE_MAX) begin
                next_strobe = 1'b1;
            end
            unique case (state)
                TRS_IDLE: begin
                    // Only a start leaves idle; other events are dropped
                    if (start_req) begin
                        next_state    = TRS_RUN;
                        next_done_mem = 1'b0;
                    end
                end
                TRS_RUN: begin
                    // One event a cycle; this order is the priority
                    if (e.prog_end) begin
                        next_state    = TRS_IDLE;
                        next_done_mem = 1'b1;
                    end else if (c.forced_end) begin
                        next_state = TRS_STOP;
                    end else if (e.code_out
                                 && e.code <= `TRS_CODE_WAIT_MAX) begin
                        next_state      = TRS_CODE;
                        next_reset_seen = 1'b0;
                    end else if (e.opt_stop && c.opt_input) begin
                        next_state     = TRS_OPT;
                        next_kind_stop = 1'b1;
                    end else if (e.opt_interp && !c.opt_input) begin
                        next_state     = TRS_OPT;
                        next_kind_stop = 1'b0;
                    end
                end
                TRS_OPT: begin
                    // Stop waits for off, interpolation waits for on
                    if (kind_stop ? !c.opt_input : c.opt_input) begin
                        next_state = TRS_RUN;
                    end
                end
                TRS_CODE: begin
                    // Needs a full on-then-off of the reset bit
                    if (c.code_reset) begin
                        next_reset_seen = 1'b1;
                    end else if (reset_seen) begin
                        next_state  = TRS_RUN;
                        next_strobe = 1'b0;
                    end
                end
                TRS_STOP: begin
                    // Running stays up until the axes are still
                    if (e.axes_stopped) begin
                        next_state = TRS_IDLE;
                    end
                end
                default: begin
                    // A broken one-hot code falls back to idle
                    next_state = TRS_IDLE;
                end
            endcase
            // Leaving automatic mode wipes the run flags at once
            if (auto_f && !next_auto_f) begin
                next_state  = TRS_IDLE;
                next_strobe = 1'b0;
            end
            // Engine commands; a teach start needs no mode flag, only a start edge needs automatic
            next_cmd.start        = (state == TRS_IDLE) && start_req;
            next_cmd.run_go       = (next_state == TRS_RUN);
            // Copies of the host bits, auto_mode gated by init_done; the engine acts on them
            next_cmd.pause        = c.pause;
            next_cmd.forced_end   = c.forced_end;
            next_cmd.single_block = c.single_block;
            next_cmd.auto_mode    = next_auto_f && !next_manual_f;
        end

        // Flags and engine commands, all registered
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state      <= TRS_IDLE;
                auto_f     <= 1'b0;
                manual_f   <= 1'b0;
                done_mem   <= 1'b0;
                cs_prev    <= 1'b0;
                cs_recv    <= 1'b0;
                strobe     <= 1'b0;
                reset_seen <= 1'b0;
                kind_stop  <= 1'b0;
                eng_cmd[t] <= '0;
            end else begin
                state      <= next_state;
                auto_f     <= next_auto_f;
                manual_f   <= next_manual_f;
                done_mem   <= next_done_mem;
                cs_prev    <= ctrl[t].cycle_start;
                cs_recv    <= next_cs_recv;
                strobe     <= next_strobe;
                reset_seen <= next_reset_seen;
                kind_stop  <= next_kind_stop;
                eng_cmd[t] <= next_cmd;
            end
        end

        // Status word; completed is hidden outside automatic mode
        always_comb begin
            stat           = '0;
            stat.auto_mode = auto_f;
            stat.manual    = manual_f;
            stat.running   = (state != TRS_IDLE);
            stat.completed = done_mem && auto_f;
            stat.opt_wait  = (state == TRS_OPT);
            stat.code_wait = (state == TRS_CODE);
            stat.strobe    = strobe;
            stat.cs_recv   = cs_recv;
        end

        assign status_all[t*`TRS_STAT_W +: `TRS_STAT_W] = stat;
    end

endmodule : trs_task_status

// ==== trs_task_status_props.sv ====
// Checker of APB timing and status flag relations of the run-status block
module trs_task_status_props #(
    parameter int unsigned INIT_CYCLES = 20,
    parameter int unsigned ADDR_W      = 8
) (
    // Clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // APB slave side
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ADDR_W-1:0]           paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // Engine side and initialization
    input wire trs_pkg::trs_event_type [1:0] eng_event,
    input wire trs_pkg::trs_cmd_type   [1:0] eng_cmd,
    input wire logic                        init_done
);
    timeunit 1ns;
    timeprecision 1ps;
    import trs_pkg::*;
    logic [31:0] cyc;
    logic [31:0] next_cyc;
    logic        st_rd;

    // Any completed read of a status word
    assign st_rd = pready && !pwrite
        && (paddr[7:0] == 8'h2C || paddr[7:0] == 8'h34);

    // Edge count since reset release, saturating so it never wraps
    always_comb begin
        next_cyc = cyc + {31'h0, cyc != 32'hFFFFFFFF};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= 32'h0;
        end else begin
            cyc <= next_cyc;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence

    apb_wait_a: assert property (setup_s |=> answer_s)
        else $error("APB answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    mode_excl_a: assert property (st_rd |-> !(prdata[2] && prdata[3]))
        else $error("automatic and manual flags both on");
    manual_clear_a: assert property (st_rd && prdata[3] |-> prdata[7:4] == 4'h0)
        else $error("run flags on in manual mode");
    wait_run_a: assert property (st_rd && prdata[7] |-> prdata[4])
        else $error("code wait without running flag");
    wait_strobe_a: assert property (st_rd && prdata[7] |-> prdata[8])
        else $error("code wait without strobe");
    done_run_a: assert property (st_rd && prdata[5] |-> !prdata[4])
        else $error("completed and running both on");
    init_off_a: assert property (st_rd && !init_done |-> prdata[3:2] == 2'h0)
        else $error("mode flag on before initialization end");
    init_early_a: assert property (cyc + 32'h2 < INIT_CYCLES |-> !init_done)
        else $error("initialization ended too early");
    init_late_a: assert property (cyc > INIT_CYCLES + 32'h2 |-> init_done)
        else $error("initialization not ended in time");
endmodule : trs_task_status_props

bind trs_task_status trs_task_status_props #(
    .INIT_CYCLES(INIT_CYCLES), .ADDR_W(ADDR_W)
) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eng_event(eng_event),
    .eng_cmd(eng_cmd), .init_done(init_done)
);

// ==== trs_engine_model.sv ====
// Program engine model: event pulses and a slow axis stop
module trs_engine_model (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // Engine side of the block
    input  wire trs_pkg::trs_cmd_type   [1:0] eng_cmd,
    output trs_pkg::trs_event_type      [1:0] eng_event
);
    timeunit 1ns;
    timeprecision 1ps;
    import trs_pkg::*;
    trs_event_type [1:0] pulse;
    logic [3:0]          fe_cnt [2];
    logic [3:0]          next_fe_cnt [2];

    initial pulse = '0;

    // Axes take eight cycles to stop, so a deceleration is visible
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_fe_cnt[i] = 4'h0;
            if (eng_cmd[i].forced_end) begin
                next_fe_cnt[i] = fe_cnt[i] + {3'h0, fe_cnt[i] != 4'h8};
            end
            eng_event[i] = pulse[i];
            eng_event[i].axes_stopped = (fe_cnt[i] == 4'h8);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fe_cnt[0] <= 4'h0;
            fe_cnt[1] <= 4'h0;
        end else begin
            fe_cnt <= next_fe_cnt;
        end
    end

    // One-cycle pulse; the spare edge keeps two calls apart
    task automatic fire(input int i, input logic [16:0] v);
        pulse[i] <= v;
        @(posedge pclk);
        pulse[i] <= '0;
        @(posedge pclk);
    endtask : fire
endmodule : trs_engine_model

// ==== trs_task_status_tb.sv ====
// Self-checking bench of the run-status block
module trs_task_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import trs_pkg::*;
    localparam logic [7:0]  C1 = 8'h00, C2 = 8'h04, S1 = 8'h2C, S2 = 8'h34;
    localparam logic [16:0] PEND = 17'h10000, TEACH = 17'h00001;
    localparam logic [16:0] OPTI = 17'h00004, OPTS = 17'h00008;
    localparam logic [16:0] STEP = 17'h00010;
    localparam logic [16:0] M499 = 17'h0BE60, M500 = 17'h0BE80;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                init_done;
    trs_event_type [1:0] eng_event;
    trs_cmd_type   [1:0] eng_cmd;
    int                  fail_count = 0;
    int                  num_checks = 0;

    always #2.5 pclk = ~pclk;

    trs_task_status #(.INIT_CYCLES(40)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eng_event(eng_event),
        .eng_cmd(eng_cmd), .init_done(init_done));
    trs_engine_model eng (.pclk(pclk), .presetn(presetn),
        .eng_cmd(eng_cmd), .eng_event(eng_event));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    // One APB transfer, held until pready is seen, bounded wait
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        if (pready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic ctl(input logic [7:0] a, input logic [6:0] c);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {25'h0, c}, q, e);
    endtask : ctl

    task automatic st(input logic [7:0] a, input logic [15:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, {16'h0, x});
    endtask : st

    task automatic t_init;
        int n;
        ctl(C1, 7'h01);
        ctl(C2, 7'h00);
        st(S1, 16'h0000);
        for (n = 0; n < 200 && init_done !== 1'b1; n++) begin
            @(posedge pclk);
        end
        if (n == 200) begin
            fail_count++;
            end_of_test();
        end
        st(S1, 16'h0004);
        st(S2, 16'h0008);
        $display("t_init done");
    endtask : t_init

    task automatic t_run;
        ctl(C1, 7'h03);
        st(S1, 16'h0214);
        chk({31'h0, eng_cmd[0].run_go}, 32'h1);
        eng.fire(0, PEND);
        st(S1, 16'h0224);
        ctl(C1, 7'h01);
        st(S1, 16'h0024);
        ctl(C1, 7'h03);
        st(S1, 16'h0214);
        eng.fire(0, M499);
        st(S1, 16'h0394);
        ctl(C1, 7'h23);
        st(S1, 16'h0394);
        ctl(C1, 7'h03);
        st(S1, 16'h0214);
        eng.fire(0, M500);
        st(S1, 16'h0314);
        eng.fire(0, STEP);
        st(S1, 16'h0214);
        $display("t_run done");
    endtask : t_run

    task automatic t_opt;
        eng.fire(0, OPTI);
        st(S1, 16'h0254);
        ctl(C1, 7'h43);
        st(S1, 16'h0214);
        eng.fire(0, OPTS);
        st(S1, 16'h0254);
        ctl(C1, 7'h03);
        st(S1, 16'h0214);
        eng.fire(0, PEND);
        st(S1, 16'h0224);
        $display("t_opt done");
    endtask : t_opt

    task automatic t_manual;
        ctl(C1, 7'h00);
        st(S1, 16'h0008);
        chk({31'h0, eng_cmd[0].auto_mode}, 32'h0);
        ctl(C1, 7'h02);
        st(S1, 16'h0008);
        ctl(C1, 7'h01);
        st(S1, 16'h0024);
        ctl(C1, 7'h03);
        eng.fire(0, M499);
        ctl(C1, 7'h00);
        st(S1, 16'h0008);
        $display("t_manual done");
    endtask : t_manual

    task automatic t_teach;
        ctl(C1, 7'h01);
        eng.fire(0, TEACH);
        st(S1, 16'h0014);
        ctl(C1, 7'h19);
        st(S1, 16'h0014);
        chk({30'h0, eng_cmd[0].pause, eng_cmd[0].forced_end}, 32'h3);
        repeat (12) @(posedge pclk);
        st(S1, 16'h0004);
        ctl(C1, 7'h01);
        $display("t_teach done");
    endtask : t_teach

    task automatic t_task2;
        logic [31:0] q;
        logic        e;
        ctl(C2, 7'h05);
        ctl(C2, 7'h07);
        st(S2, 16'h0214);
        chk({31'h0, eng_cmd[1].single_block}, 32'h1);
        st(S1, 16'h0004);
        eng.fire(1, PEND);
        st(S2, 16'h0224);
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk({e, q[30:0]}, 32'h80000000);
        apb(1'b1, S1, 32'h0000FFFF, q, e);
        st(S1, 16'h0004);
        $display("t_task2 done");
    endtask : t_task2

    // Reset for three cycles, then the scenarios in order
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_init();
        t_run();
        t_opt();
        t_manual();
        t_teach();
        t_task2();
        end_of_test();
    end
endmodule : trs_task_status_tb
